// >>> logic/lmd_pkg.sv
// constants for the low memory address decoder
// assumes a 40-bit system address and byte addressing
package lmd_pkg;
  localparam int ADDR_W = 40;
  // compatibility segment bases, all 16 KB granular except upper bios
  localparam logic [39:0] EXP_BASE     = 40'h00_000C_0000;
  localparam logic [39:0] LSB_BASE     = 40'h00_000E_0000;
  localparam logic [39:0] USB_BASE     = 40'h00_000F_0000;
  localparam logic [39:0] ONE_MB       = 40'h00_0010_0000;
  localparam logic [39:0] FOUR_GB      = 40'h01_0000_0000;
  localparam int          SEG_SHIFT    = 14;   // 16 KB segment
  localparam int          WIN_SHIFT    = 28;   // 256 MB window
  localparam int          NUM_EXP_SEG  = 8;
  localparam int          NUM_LSB_SEG  = 4;
  localparam int          NUM_ATTR     = 13;
  // attribute codes: bit1 = reads to memory, bit0 = writes to memory
  localparam logic [1:0]  ATTR_PORT    = 2'h0;
  localparam logic [1:0]  ATTR_RESET   = 2'h0;
  // smm top segment sizes, 512 KB .. 4 MB
  localparam logic [39:0] SMM_SZ_512K  = 40'h00_0008_0000;
  localparam logic [39:0] SMM_SZ_1M    = 40'h00_0010_0000;
  localparam logic [39:0] SMM_SZ_2M    = 40'h00_0020_0000;
  localparam logic [39:0] SMM_SZ_4M    = 40'h00_0040_0000;
  // value is arbitrary; shared reset of top, smm top and window base
  localparam logic [39:0] LOW_TOP_RST  = 40'h00_8000_0000;
  typedef enum logic [1:0] {
    LMD_DST_MEM   = 2'b00,
    LMD_DST_PORT  = 2'b01,
    LMD_DST_ABORT = 2'b10,
    LMD_DST_CFG   = 2'b11
  } lmd_dst_e;
endpackage

// >>> logic/lmd_decoder.sv
// low memory address decoder: one registered destination per request
// assumes requests arrive as single-cycle valid strobes, synchronous to i_mclk
// Functional notes
// - expansion bios area split into eight 16 KB segments with own attributes
// - two-bit code chooses port or memory for reads and writes separately
// - expansion segments reset to port for both reads and writes
// - lower system bios area is four 16 KB independently attributed segments
// - lower system bios segments reset to the compatibility port
// - upper bios is one 64 KB segment, resets to port, memory disabled
// - locked shadow accesses complete; atomicity not kept if destinations differ
// - disabled shadow memory is never relocated elsewhere
// - 1 MB up to low memory top routes to system memory
// - no hole at 15-16 MB; that range is ordinary memory
// - smm top segment hit: memory with qualifier, master abort without
// - smm segment spans top minus selected size up to top
// - smm segment top resets to low memory top reset value, relocatable
// - inbound accesses to smm memory blocked; crossing locks unsupported
// - writebacks accepted into smm regardless of qualifier, no error flag
// - one relocatable 256 MB config window; address picks the register
// - config window base resets to the low memory top reset value
// - config window base may sit above or below 4 GB
`timescale 1ns/1ps
`default_nettype none
module lmd_decoder #(
  parameter int ADDR_W = 40
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  // configuration writes from the register block
  input  wire logic                     i_attr_we,
  input  wire logic [3:0]               i_attr_idx,
  input  wire logic [1:0]               i_attr_val,
  input  wire logic                     i_low_top_we,
  input  wire logic [ADDR_W-1:0]        i_low_top_val,
  input  wire logic                     i_smm_top_we,
  input  wire logic [ADDR_W-1:0]        i_smm_top_val,
  input  wire logic                     i_smm_en,
  input  wire logic [1:0]               i_smm_size,
  input  wire logic                     i_cfg_base_we,
  input  wire logic [ADDR_W-1:0]        i_cfg_base_val,
  input  wire logic                     i_err_clr,
  // request
  input  wire logic                     i_req_valid,
  input  wire logic [ADDR_W-1:0]        i_req_addr,
  input  wire logic                     i_req_write,
  input  wire logic                     i_req_inbound,
  input  wire logic                     i_req_smm_qual,
  input  wire logic                     i_req_ewb,
  input  wire logic                     i_req_iwb,
  // answer
  output logic                          o_rsp_valid,
  output lmd_pkg::lmd_dst_e             o_rsp_dst,
  output logic [lmd_pkg::WIN_SHIFT-1:0] o_rsp_cfg_offset,
  output logic                          o_smm_error,
  output logic [ADDR_W-1:0]             o_low_top,
  output logic [ADDR_W-1:0]             o_smm_top,
  output logic [ADDR_W-1:0]             o_cfg_base
);
  import lmd_pkg::*;

  logic [1:0]        attr_r [NUM_ATTR];
  logic [ADDR_W-1:0] low_top_r;
  logic [ADDR_W-1:0] smm_top_r;
  logic [ADDR_W-1:0] cfg_base_r;
  logic              smm_en_r;
  logic [1:0]        smm_size_r;

  // segment size in bytes for the size field; the largest size is the
  // default branch so an unknown code never shrinks the protected span
  function automatic logic [ADDR_W-1:0] smm_bytes(input logic [1:0] sel);
    case (sel)
      2'd0:    smm_bytes = SMM_SZ_512K[ADDR_W-1:0];
      2'd1:    smm_bytes = SMM_SZ_1M[ADDR_W-1:0];
      2'd2:    smm_bytes = SMM_SZ_2M[ADDR_W-1:0];
      default: smm_bytes = SMM_SZ_4M[ADDR_W-1:0];
    endcase
  endfunction

  // shadow attribute registers, index 0..7 expansion, 8..11 lower, 12 upper
  // indices 13..15 match no register, so a stray write there is dropped
  // all codes reset to 00, which keeps both directions on the port
  genvar g;
  generate
    for (g = 0; g < NUM_ATTR; g++) begin : g_attr
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          attr_r[g] <= ATTR_RESET;
        end else if (i_attr_we && (i_attr_idx == 4'(g))) begin
          attr_r[g] <= i_attr_val;
        end
      end
    end
  endgenerate

  // top of low memory and smm segment top share one reset value
  // the smm top loads on its own so the segment can be set up before
  // the memory top is known
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_top_r <= LOW_TOP_RST[ADDR_W-1:0];
      smm_top_r <= LOW_TOP_RST[ADDR_W-1:0];
    end else begin
      if (i_low_top_we) begin
        low_top_r <= i_low_top_val;
      end
      if (i_smm_top_we) begin
        smm_top_r <= i_smm_top_val;
      end
    end
  end

  // smm enable and size, registered like the other decode inputs
  // a change takes effect one cycle later; requests in that cycle
  // still see the old segment
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smm_en_r   <= 1'b0;
      smm_size_r <= 2'h0;
    end else begin
      smm_en_r   <= i_smm_en;
      smm_size_r <= i_smm_size;
    end
  end

  // config window base, full width so it may sit above 4 GB
  // low bits are dropped on load: the window is always 256 MB aligned
  // moving it under traffic is the caller's hazard, nothing here fences it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_base_r <= LOW_TOP_RST[ADDR_W-1:0];
    end else if (i_cfg_base_we) begin
      cfg_base_r <= {i_cfg_base_val[ADDR_W-1:WIN_SHIFT], {WIN_SHIFT{1'b0}}};
    end
  end

  // address span test shared by the smm, low memory and shadow segment ranges
  // upper bound is exclusive so adjacent ranges never both hit
  function automatic logic in_span(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] lo,
                                   input logic [ADDR_W-1:0] hi);
    in_span = (a >= lo) && (a < hi);
  endfunction

  // shadow code to a destination; bit1 steers reads, bit0 steers writes
  function automatic lmd_dst_e shadow_route(input logic [1:0] code,
                                            input logic       wr);
    logic to_mem;
    to_mem       = wr ? code[0] : code[1];
    shadow_route = to_mem ? LMD_DST_MEM : LMD_DST_PORT;
  endfunction

  // lowest byte of shadow segment idx: eight expansion, four lower, one upper
  function automatic logic [ADDR_W-1:0] seg_lo_of(input int idx);
    logic [ADDR_W-1:0] lo;
    if (idx >= NUM_EXP_SEG + NUM_LSB_SEG) begin
      lo = USB_BASE[ADDR_W-1:0];
    end else if (idx >= NUM_EXP_SEG) begin
      lo = LSB_BASE[ADDR_W-1:0] + (ADDR_W'(idx - NUM_EXP_SEG) << SEG_SHIFT);
    end else begin
      lo = EXP_BASE[ADDR_W-1:0] + (ADDR_W'(idx) << SEG_SHIFT);
    end
    seg_lo_of = lo;
  endfunction

  // first byte past segment idx; the upper segment runs on to 1 MB
  function automatic logic [ADDR_W-1:0] seg_hi_of(input int idx);
    logic [ADDR_W-1:0] hi;
    if (idx >= NUM_EXP_SEG + NUM_LSB_SEG) begin
      hi = ONE_MB[ADDR_W-1:0];
    end else begin
      hi = seg_lo_of(idx) + (ADDR_W'(1) << SEG_SHIFT);
    end
    seg_hi_of = hi;
  endfunction

  // winning range of a request; kept apart from the destination so the
  // priority order can be read in one place
  typedef enum logic [2:0] {
    LMD_RGN_CFG    = 3'b000,
    LMD_RGN_SMM    = 3'b001,
    LMD_RGN_SHADOW = 3'b010,
    LMD_RGN_LOW    = 3'b011,
    LMD_RGN_OTHER  = 3'b100
  } lmd_rgn_e;

  // per-request decode, all against the registers as they stand this cycle
  logic [ADDR_W-1:0]   smm_span;
  logic [ADDR_W-1:0]   smm_lo;
  logic                in_cfg;
  logic                in_smm;
  logic                in_low;
  logic                in_shadow;
  logic [NUM_ATTR-1:0] seg_hit;
  logic [1:0]          seg_code [NUM_ATTR];
  logic [1:0]          seg_attr;
  lmd_dst_e            seg_dst;
  lmd_dst_e            smm_dst;
  logic                smm_err;
  lmd_rgn_e            rgn;
  lmd_dst_e            dst_nxt;
  logic                err_nxt;

  // smm top segment; a top below the span clamps the base at zero so the
  // segment never wraps round to the top of the address space
  assign smm_span = smm_bytes(smm_size_r);
  assign smm_lo   = (smm_top_r > smm_span) ? (smm_top_r - smm_span) : '0;
  assign in_smm   = smm_en_r && in_span(i_req_addr, smm_lo, smm_top_r);

  // window compare on the upper bits only; the base is kept aligned
  assign in_cfg = (i_req_addr[ADDR_W-1:WIN_SHIFT] == cfg_base_r[ADDR_W-1:WIN_SHIFT]);

  // main memory from 1 MB to the programmed top; no isa hole is carved out
  // a top at or below 1 MB simply leaves this range empty
  assign in_low = in_span(i_req_addr, ONE_MB[ADDR_W-1:0], low_top_r);

  // one hit per shadow segment; bounds are constants, so each is a pair of
  // comparators and no computed index ever reaches past the attribute array
  generate
    for (g = 0; g < NUM_ATTR; g++) begin : g_seg
      localparam logic [ADDR_W-1:0] SEG_LO = seg_lo_of(g);
      localparam logic [ADDR_W-1:0] SEG_HI = seg_hi_of(g);
      assign seg_hit[g]  = in_span(i_req_addr, SEG_LO, SEG_HI);
      assign seg_code[g] = seg_hit[g] ? attr_r[g] : 2'b00;
    end
  endgenerate

  // at most one segment hits, so an or of the masked codes picks its code
  always_comb begin
    seg_attr = 2'b00;
    for (int k = 0; k < NUM_ATTR; k++) begin
      seg_attr = seg_attr | seg_code[k];
    end
  end

  // a shadow hit is any segment hit
  assign in_shadow = |seg_hit;
  // locked cycles take the same path; no atomic pairing is attempted
  assign seg_dst   = shadow_route(seg_attr, i_req_write);

  // inside the smm segment: inbound is refused first, then writebacks are
  // absorbed whatever the qualifier says, then the qualifier decides
  always_comb begin
    smm_dst = LMD_DST_ABORT;
    smm_err = 1'b1;
    if (i_req_inbound) begin
      smm_dst = LMD_DST_ABORT;
      smm_err = 1'b1;
    end else if (i_req_ewb || i_req_iwb) begin
      smm_dst = LMD_DST_MEM;
      smm_err = 1'b0;
    end else if (i_req_smm_qual) begin
      smm_dst = LMD_DST_MEM;
      smm_err = 1'b0;
    end else begin
      smm_dst = LMD_DST_ABORT;
      smm_err = 1'b1;
    end
  end

  // range priority: window, smm segment, shadow, low memory, then the port
  // overlapping ranges are a software error and the lower one just loses
  always_comb begin
    if (in_cfg) begin
      rgn = LMD_RGN_CFG;
    end else if (in_smm) begin
      rgn = LMD_RGN_SMM;
    end else if (in_shadow) begin
      rgn = LMD_RGN_SHADOW;
    end else if (in_low) begin
      rgn = LMD_RGN_LOW;
    end else begin
      rgn = LMD_RGN_OTHER;
    end
  end

  // destination and error event of the winning range
  // everything unclaimed, including space below the shadow area, goes to the port
  always_comb begin
    dst_nxt = LMD_DST_PORT;
    err_nxt = 1'b0;
    case (rgn)
      LMD_RGN_CFG: begin
        dst_nxt = LMD_DST_CFG;
      end
      LMD_RGN_SMM: begin
        dst_nxt = smm_dst;
        err_nxt = smm_err;
      end
      LMD_RGN_SHADOW: begin
        dst_nxt = seg_dst;
      end
      LMD_RGN_LOW: begin
        dst_nxt = LMD_DST_MEM;
      end
      default: begin
        dst_nxt = LMD_DST_PORT;
      end
    endcase
  end

  // answer strobe: exactly one cycle per accepted request, never merged
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_valid <= 1'b0;
    end else begin
      o_rsp_valid <= i_req_valid;
    end
  end

  // answer payload holds until the next request, so a slow reader still sees it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rsp_dst        <= LMD_DST_PORT;
      o_rsp_cfg_offset <= '0;
    end else if (i_req_valid) begin
      o_rsp_dst        <= dst_nxt;
      o_rsp_cfg_offset <= i_req_addr[WIN_SHIFT-1:0];
    end
  end

  // sticky smm error; a new event wins over a clear in the same cycle
  // so an abort landing on the clear strobe is never lost
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_smm_error <= 1'b0;
    end else if (i_req_valid && err_nxt) begin
      o_smm_error <= 1'b1;
    end else if (i_err_clr) begin
      o_smm_error <= 1'b0;
    end
  end

  // register values shown as they stand, for the bench and for software reads
  // no extra flop: these already come straight from registers
  assign o_low_top  = low_top_r;
  assign o_smm_top  = smm_top_r;
  assign o_cfg_base = cfg_base_r;
endmodule
`default_nettype wire

// >>> test/lmd_decoder_properties.sv
// assertions on the decoder's request, answer and register ports
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module lmd_decoder_properties (
  input wire logic              i_mclk,
  input wire logic              i_rst_n,
  input wire logic              i_low_top_we,
  input wire logic [39:0]       i_low_top_val,
  input wire logic              i_err_clr,
  input wire logic              i_req_valid,
  input wire logic [39:0]       i_req_addr,
  input wire logic              i_req_inbound,
  input wire logic              i_req_smm_qual,
  input wire logic              i_req_ewb,
  input wire logic              i_req_iwb,
  input wire logic              o_rsp_valid,
  input var  lmd_pkg::lmd_dst_e o_rsp_dst,
  input wire logic [27:0]       o_rsp_cfg_offset,
  input wire logic              o_smm_error,
  input wire logic [39:0]       o_low_top,
  input wire logic [39:0]       o_smm_top,
  input wire logic [39:0]       o_cfg_base
);
  import lmd_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // answer timing: exactly one strobe per request, none otherwise
  chk_rsp_one_cycle: assert property (i_req_valid |=> o_rsp_valid)
    else $error("no answer one cycle after request");
  chk_no_spurious: assert property (!i_req_valid |=> !o_rsp_valid)
    else $error("answer without a request");
  // destinations tied to the address and the registers before the edge
  chk_low_mem: assert property (i_req_valid && i_req_addr >= ONE_MB && i_req_addr < o_low_top
    && i_req_addr < o_smm_top - SMM_SZ_4M && i_req_addr < o_cfg_base |=> o_rsp_dst == LMD_DST_MEM)
    else $error("low memory request not sent to memory");
  chk_cfg_window: assert property (i_req_valid && i_req_addr[39:28] == o_cfg_base[39:28]
    |=> o_rsp_dst == LMD_DST_CFG && o_rsp_cfg_offset == 28'($past(i_req_addr)))
    else $error("window hit not decoded with its offset");
  chk_abort_cause: assert property (o_rsp_valid && o_rsp_dst == LMD_DST_ABORT |->
    !$past(i_req_ewb) && !$past(i_req_iwb) && ($past(i_req_inbound) || !$past(i_req_smm_qual)))
    else $error("abort without an unqualified or inbound request");
  chk_err_sticky: assert property (o_smm_error && !i_err_clr |=> o_smm_error)
    else $error("error flag dropped without clear");
  chk_low_top_load: assert property (i_low_top_we |=> o_low_top == $past(i_low_top_val))
    else $error("low memory top not loaded");
  chk_base_align: assert property (o_cfg_base[27:0] == 28'h000_0000)
    else $error("window base not 256 MB aligned");
endmodule
bind lmd_decoder lmd_decoder_properties i_lmd_decoder_properties (.i_mclk, .i_rst_n,
  .i_low_top_we, .i_low_top_val, .i_err_clr, .i_req_valid, .i_req_addr, .i_req_inbound,
  .i_req_smm_qual, .i_req_ewb, .i_req_iwb, .o_rsp_valid, .o_rsp_dst, .o_rsp_cfg_offset,
  .o_smm_error, .o_low_top, .o_smm_top, .o_cfg_base);
`default_nettype wire

// >>> test/lmd_rsp_sink.sv
// far-side agent that takes every routed answer of the decoder
// assumes answers are single-cycle strobes on i_mclk
`timescale 1ns/1ps
`default_nettype none
module lmd_rsp_sink (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_rsp_valid,
  output logic [15:0]      o_count
);
  // counted, so a merged or dropped answer shows at the end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) o_count <= 16'h0000;
    else if (i_rsp_valid) o_count <= o_count + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> test/test_lmd_decoder.sv
// self-checking bench for the low memory address decoder
// assumes logic/ package and decoder; one 125 MHz clock, inputs moved on falling edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_lmd_decoder;
  import lmd_pkg::*;
  logic i_mclk = 0, i_rst_n = 0, i_attr_we = 0, i_low_top_we = 0, i_smm_top_we = 0, i_smm_en = 0;
  logic i_cfg_base_we = 0, i_err_clr = 0, i_req_valid = 0, i_req_write = 0, i_req_inbound = 0;
  logic i_req_smm_qual = 0, i_req_ewb = 0, i_req_iwb = 0, o_rsp_valid, o_smm_error;
  logic [3:0]  i_attr_idx = 0;
  logic [1:0]  i_attr_val = 0, i_smm_size = 0;
  logic [39:0] i_low_top_val = 0, i_smm_top_val = 0, i_cfg_base_val = 0, i_req_addr = 0, a, sz;
  logic [39:0] o_low_top, o_smm_top, o_cfg_base;
  logic [27:0] o_rsp_cfg_offset;
  logic [15:0] o_count;
  lmd_dst_e    o_rsp_dst;
  int          n_fail = 0, cmp_count = 0, n_req = 0;
  always #4 i_mclk = ~i_mclk;
  lmd_decoder i_lmd_decoder (.i_mclk, .i_rst_n, .i_attr_we, .i_attr_idx, .i_attr_val,
    .i_low_top_we, .i_low_top_val, .i_smm_top_we, .i_smm_top_val, .i_smm_en, .i_smm_size,
    .i_cfg_base_we, .i_cfg_base_val, .i_err_clr, .i_req_valid, .i_req_addr, .i_req_write,
    .i_req_inbound, .i_req_smm_qual, .i_req_ewb, .i_req_iwb, .o_rsp_valid, .o_rsp_dst,
    .o_rsp_cfg_offset, .o_smm_error, .o_low_top, .o_smm_top, .o_cfg_base);
  lmd_rsp_sink i_lmd_rsp_sink (.i_mclk, .i_rst_n, .i_rsp_valid(o_rsp_valid), .o_count);
  // expected routing of a shadow code: bit1 reads, bit0 writes
  function automatic lmd_dst_e seg_dst(input logic [1:0] c, input logic w);
    return (w ? c[0] : c[1]) ? LMD_DST_MEM : LMD_DST_PORT;
  endfunction
  function automatic logic [39:0] seg_addr(input int s);
    if (s == 12) return USB_BASE + 40'($urandom_range(16'hFFFF));
    return EXP_BASE + (40'(s) << SEG_SHIFT) + 40'($urandom_range(16'h3FFF));
  endfunction
  // one request strobe; returns on the falling edge where the answer stands
  task automatic req(input logic [39:0] ad, input logic w, input logic [3:0] f);
    @(negedge i_mclk);
    {i_req_inbound, i_req_smm_qual, i_req_ewb, i_req_iwb} = f;
    i_req_addr = ad;
    i_req_write = w;
    i_req_valid = 1;
    n_req++;
    @(negedge i_mclk);
    i_req_valid = 0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_mclk) s = 1;
    @(negedge i_mclk) s = 0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang costs a mismatch; the full run needs well under 2000 cycles
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(74));
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk) i_rst_n = 1;
    `CHK("low_top", LOW_TOP_RST, o_low_top)
    `CHK("smm_top", LOW_TOP_RST, o_smm_top)
    `CHK("cfg_base", LOW_TOP_RST, o_cfg_base)
    // every segment, every code, both directions, starting from reset state
    for (int s = 0; s < 13; s++) begin
      for (int w = 0; w < 2; w++) begin
        req(seg_addr(s), w[0], 4'h0);
        `CHK("seg_reset", LMD_DST_PORT, o_rsp_dst)
      end
      for (int c = 0; c < 4; c++) begin
        i_attr_idx = 4'(s);
        i_attr_val = 2'(c);
        pulse(i_attr_we);
        for (int w = 0; w < 2; w++) begin
          req(seg_addr(s), w[0], 4'h0);
          `CHK("seg_code", seg_dst(2'(c), w[0]), o_rsp_dst)
        end
      end
    end
    req(seg_addr(3), 1'b1, 4'h8);
    `CHK("inbound_shadow", LMD_DST_MEM, o_rsp_dst)
    // random low memory plus both ends of the old isa hole
    repeat (20) begin
      req(ONE_MB + 40'($urandom_range(32'h7FEF_FFFF)), 1'($urandom), 4'h0);
      `CHK("low_mem", LMD_DST_MEM, o_rsp_dst)
    end
    for (int w = 0; w < 2; w++) begin
      req(w ? 40'h00_00FF_FFFF : 40'h00_00F0_0000, w[0], 4'h0);
      `CHK("no_hole", LMD_DST_MEM, o_rsp_dst)
    end
    // window moved above 4 GB while idle; old place no longer decodes
    i_cfg_base_val = 40'h12_3456_789A;
    pulse(i_cfg_base_we);
    `CHK("cfg_base", 40'h12_3000_0000, o_cfg_base)
    a = 40'h12_3000_0000 + 40'($urandom_range(32'h0FFF_FFFF));
    req(a, 1'b0, 4'h0);
    `CHK("cfg_dst", LMD_DST_CFG, o_rsp_dst)
    `CHK("cfg_off", a[27:0], o_rsp_cfg_offset)
    req(LOW_TOP_RST, 1'b0, 4'h0);
    `CHK("old_window", LMD_DST_PORT, o_rsp_dst)
    // smm segment below a relocated top, every size
    i_smm_top_val = 40'h00_4000_0000;
    pulse(i_smm_top_we);
    `CHK("smm_top", 40'h00_4000_0000, o_smm_top)
    i_smm_en = 1;
    for (int z = 0; z < 4; z++) begin
      i_smm_size = 2'(z);
      sz = SMM_SZ_512K << z;
      repeat (2) @(negedge i_mclk);
      req(40'h00_4000_0000 - sz, 1'b0, 4'h4);
      `CHK("smm_qual", LMD_DST_MEM, o_rsp_dst)
      req(40'h00_3FFF_FFFF, 1'b1, 4'h0);
      `CHK("smm_abort", LMD_DST_ABORT, o_rsp_dst)
      `CHK("smm_err", 1'b1, o_smm_error)
      req(40'h00_4000_0000 - sz - 40'h1, 1'b0, 4'h0);
      `CHK("below_smm", LMD_DST_MEM, o_rsp_dst)
      pulse(i_err_clr);
      req(40'h00_4000_0000 - sz, 1'b1, z[0] ? 4'h2 : 4'h1);
      `CHK("smm_wb", LMD_DST_MEM, o_rsp_dst)
      `CHK("wb_no_err", 1'b0, o_smm_error)
      req(40'h00_3FFF_FFFF, 1'b0, 4'hC);
      `CHK("smm_inbound", LMD_DST_ABORT, o_rsp_dst)
      pulse(i_err_clr);
    end
    // lowered top of low memory sends the space above it to the port
    i_low_top_val = 40'h00_6000_0000;
    pulse(i_low_top_we);
    req(40'h00_7000_0000, 1'b0, 4'h0);
    `CHK("above_top", LMD_DST_PORT, o_rsp_dst)
    // the sink counts the last strobe one edge after req returns
    @(negedge i_mclk);
    `CHK("answers", 16'(n_req), o_count)
    summarize();
  end
endmodule
`default_nettype wire
